// ### src/apc_auto_power_down_control.sv
// Automatic power-down, bus blocking and power control register logic.
//
// Behaviour
// R1: With auto sleep enabled, idle counter starts once strobe stops toggling.
// R2: Idle counter advances on periods of the logic clock input pin.
// R3: Fifteen idle logic clock periods raise power-down flag, enter power-down.
// R4: Auto sleep enable alone permits power-down entry.
// R5: Strobe toggling again returns the device to normal operation.
// R6: Module select falling low or warm reset high also exits power-down.
// R7: Power-down blocks core address and data, deselects memories.
// R8: Logic arrays and port blocks keep running during power-down.
// R9: Power-down holds port levels, address outputs undefined, peripherals off.
// R10: Blocking the logic clock from arrays never stops the idle counter.
// R11: Set blocking bits stop their signal reaching both logic arrays.
// R12: Register A bit 3 set turns turbo mode off; zero keeps it on.
// R13: Module select high disables flash, SRAM, I/O space only.
// R14: Register A bit 1 enables automatic power-down.
// R15: Register A bits 4 and 5 disconnect logic clock from array, macrocells.
// R16: Register B bits 2..5 disconnect write, read, fetch, strobe.
// R17: Power registers clear only at power-up, not on warm reset.
// R18: Each strobe transition clears the idle counter; exits drop the flag.
// R19: Strobe is synchronised before edge detection.
module apc_auto_power_down_control #(
    parameter int ADDR_WIDTH = apc_pkg::ADDR_WIDTH,
    parameter int DATA_WIDTH = apc_pkg::DATA_WIDTH
) (
    input  wire logic                  ref_clk,
    input  wire logic                  reset,
    input  wire logic                  strobePin,
    input  wire logic                  logicClockPin,
    input  wire logic                  moduleSelectPinN,
    input  wire logic                  warmResetPin,
    input  wire logic                  regAWrite,
    input  wire logic                  regBWrite,
    input  wire logic [7:0]            regWrData,
    input  wire logic [ADDR_WIDTH-1:0] coreAddr,
    input  wire logic [DATA_WIDTH-1:0] coreData,
    input  wire logic                  coreWrN,
    input  wire logic                  coreRdN,
    input  wire logic                  coreFetchN,
    input  wire logic                  flashRequest,
    input  wire logic                  sramRequest,
    input  wire logic                  ioSpaceRequest,
    output logic [7:0]                 powerCtrlRegA,
    output logic [7:0]                 powerCtrlRegB,
    output logic                       powerDownFlag,
    output logic [ADDR_WIDTH-1:0]      blockAddr,
    output logic [DATA_WIDTH-1:0]      blockData,
    output logic                       flashSelect,
    output logic                       sramSelect,
    output logic                       ioSpaceSelect,
    output logic                       arrayWrN,
    output logic                       arrayRdN,
    output logic                       arrayFetchN,
    output logic                       arrayStrobe,
    output logic                       arrayClock,
    output logic                       macrocellClock,
    output logic                       turboModeOn,
    output logic                       portLevelHold,
    output logic                       addrOutUndefined,
    output logic                       peripheralTristate,
    output logic [3:0]                 idleCount
);

    // Power control registers and their next values.
    logic [7:0]            regA_r;
    logic [7:0]            regA_nxt;
    logic [7:0]            regB_r;
    logic [7:0]            regB_nxt;

    // Registered outputs toward memories and logic arrays.
    logic [ADDR_WIDTH-1:0] addr_r;
    logic [ADDR_WIDTH-1:0] addr_nxt;
    logic [DATA_WIDTH-1:0] data_r;
    logic [DATA_WIDTH-1:0] data_nxt;
    logic                  flashSel_r;
    logic                  sramSel_r;
    logic                  ioSel_r;
    logic                  wrN_r;
    logic                  rdN_r;
    logic                  fetchN_r;
    logic                  strobe_r;
    logic                  arrayClk_r;
    logic                  mcellClk_r;
    logic                  turbo_r;
    logic                  hold_r;

    // Synchronised pin views.
    logic                  strobeSync;
    logic                  strobeChanged;
    logic                  clockSync;
    logic                  clockRose;
    logic                  selectSyncN;
    logic                  selectFell;
    logic                  warmResetSync;

    // Decoded controls.
    logic                  autoSleepEnable;
    logic                  exitRequest;
    logic                  powerDown;
    logic                  memEnable;
    logic                  blockWr;
    logic                  blockRd;
    logic                  blockFetch;
    logic                  blockStrobe;
    logic                  blockArrayClk;
    logic                  blockMcellClk;

    // Next values of the registered outputs.
    logic                  flashSel_nxt;
    logic                  sramSel_nxt;
    logic                  ioSel_nxt;
    logic                  wrN_nxt;
    logic                  rdN_nxt;
    logic                  fetchN_nxt;
    logic                  strobe_nxt;
    logic                  arrayClk_nxt;
    logic                  mcellClk_nxt;
    logic                  turbo_nxt;
    logic                  hold_nxt;

    apc_sync u_strobe_sync (
        .ref_clk (ref_clk),
        .reset   (reset),
        .asyncIn (strobePin),
        .syncOut (strobeSync),
        .changed (strobeChanged), // R19
        .rose    (),
        .fell    ()
    );

    apc_sync u_clock_sync (
        .ref_clk (ref_clk),
        .reset   (reset),
        .asyncIn (logicClockPin),
        .syncOut (clockSync),
        .changed (),
        .rose    (clockRose), // R2
        .fell    ()
    );

    apc_sync u_select_sync (
        .ref_clk (ref_clk),
        .reset   (reset),
        .asyncIn (moduleSelectPinN),
        .syncOut (selectSyncN),
        .changed (),
        .rose    (),
        .fell    (selectFell)
    );

    apc_sync u_reset_sync (
        .ref_clk (ref_clk),
        .reset   (reset),
        .asyncIn (warmResetPin),
        .syncOut (warmResetSync),
        .changed (),
        .rose    (),
        .fell    ()
    );

    // Register field decode.
    assign autoSleepEnable = regA_r[apc_pkg::REGA_AUTO_SLEEP_EN]; // R14
    assign blockArrayClk   = regA_r[apc_pkg::REGA_ARRAY_CLK_OFF]; // R15
    assign blockMcellClk   = regA_r[apc_pkg::REGA_MCELL_CLK_OFF]; // R15
    assign blockWr         = regB_r[apc_pkg::REGB_WR_OFF]; // R16
    assign blockRd         = regB_r[apc_pkg::REGB_RD_OFF]; // R16
    assign blockFetch      = regB_r[apc_pkg::REGB_FETCH_OFF]; // R16
    assign blockStrobe     = regB_r[apc_pkg::REGB_STROBE_OFF]; // R16

    // An edge on the select pin is used so a permanently selected module
    // can still sleep; a held warm reset keeps the unit awake.
    assign exitRequest = selectFell | warmResetSync; // R6

    // The idle counter sees the raw synchronised clock, whatever the
    // array clock blocking bits say.
    apc_sleep_counter #(
        .CNT_WIDTH (apc_pkg::IDLE_CNT_WIDTH)
    ) u_auto_sleep_unit (
        .ref_clk        (ref_clk),
        .reset          (reset),
        .enable         (autoSleepEnable), // R4
        .strobeActivity (strobeChanged), // R18
        .clockTick      (clockRose), // R10
        .exitRequest    (exitRequest),
        .idleLimit      (apc_pkg::IDLE_LIMIT),
        .powerDownFlag  (powerDown),
        .idleCount      (idleCount)
    );

    // Register writes; only the power-up reset clears them.
    assign regA_nxt = regAWrite ? regWrData : regA_r;
    assign regB_nxt = regBWrite ? regWrData : regB_r;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            regA_r <= apc_pkg::REGA_RESET; // R17
            regB_r <= apc_pkg::REGB_RESET; // R17
        end else begin
            regA_r <= regA_nxt;
            regB_r <= regB_nxt;
        end
    end

    // Holding the last value rather than forcing a constant keeps the
    // memory inputs still, which is the whole point of blocking.
    assign addr_nxt  = powerDown ? addr_r : coreAddr; // R7
    assign data_nxt  = powerDown ? data_r : coreData; // R7

    // Select high only gates the memory selects, never the arrays.
    assign memEnable = ~powerDown & ~selectSyncN; // R7 R13
    // Selects are masked rather than frozen, so a deselected memory sees
    // no access at all.
    assign flashSel_nxt = flashRequest & memEnable; // R13
    assign sramSel_nxt  = sramRequest & memEnable; // R13
    assign ioSel_nxt    = ioSpaceRequest & memEnable; // R13

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            addr_r     <= apc_pkg::ADDR_RESET;
            data_r     <= apc_pkg::DATA_RESET;
            flashSel_r <= 1'b0;
            sramSel_r  <= 1'b0;
            ioSel_r    <= 1'b0;
        end else begin
            addr_r     <= addr_nxt;
            data_r     <= data_nxt;
            flashSel_r <= flashSel_nxt;
            sramSel_r  <= sramSel_nxt;
            ioSel_r    <= ioSel_nxt;
        end
    end

    // Control strobes toward both logic arrays; power-down leaves them
    // alone so the arrays stay responsive.
    assign wrN_nxt    = blockWr ? apc_pkg::STROBE_N_IDLE : coreWrN; // R11
    assign rdN_nxt    = blockRd ? apc_pkg::STROBE_N_IDLE : coreRdN; // R11
    assign fetchN_nxt = blockFetch ? apc_pkg::STROBE_N_IDLE
                                   : coreFetchN; // R11
    assign strobe_nxt = blockStrobe ? apc_pkg::STROBE_IDLE : strobeSync; // R11

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wrN_r    <= apc_pkg::STROBE_N_IDLE;
            rdN_r    <= apc_pkg::STROBE_N_IDLE;
            fetchN_r <= apc_pkg::STROBE_N_IDLE;
            strobe_r <= apc_pkg::STROBE_IDLE;
        end else begin
            wrN_r    <= wrN_nxt;
            rdN_r    <= rdN_nxt;
            fetchN_r <= fetchN_nxt;
            strobe_r <= strobe_nxt;
        end
    end

    // Logic clock copies run in power-down as well; only blocking bits
    // stop them.
    assign arrayClk_nxt = clockSync & ~blockArrayClk; // R8 R15
    assign mcellClk_nxt = clockSync & ~blockMcellClk; // R8 R15

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            arrayClk_r <= 1'b0;
            mcellClk_r <= 1'b0;
        end else begin
            arrayClk_r <= arrayClk_nxt;
            mcellClk_r <= mcellClk_nxt;
        end
    end

    // Turbo and port status follow the register and power-down state.
    assign turbo_nxt = ~regA_r[apc_pkg::REGA_TURBO_OFF]; // R12
    assign hold_nxt  = powerDown; // R9

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            turbo_r <= 1'b1;
            hold_r  <= 1'b0;
        end else begin
            turbo_r <= turbo_nxt;
            hold_r  <= hold_nxt;
        end
    end

    assign powerCtrlRegA      = regA_r;
    assign powerCtrlRegB      = regB_r;
    assign powerDownFlag      = powerDown; // R3
    assign blockAddr          = addr_r;
    assign blockData          = data_r;
    assign flashSelect        = flashSel_r;
    assign sramSelect         = sramSel_r;
    assign ioSpaceSelect      = ioSel_r;
    assign arrayWrN           = wrN_r;
    assign arrayRdN           = rdN_r;
    assign arrayFetchN        = fetchN_r;
    assign arrayStrobe        = strobe_r;
    assign arrayClock         = arrayClk_r;
    assign macrocellClock     = mcellClk_r;
    assign turboModeOn        = turbo_r;
    assign portLevelHold      = hold_r; // R9
    assign addrOutUndefined   = hold_r; // R9
    assign peripheralTristate = hold_r; // R9

endmodule // apc_auto_power_down_control

// ### src/apc_pkg.sv
// Shared constants for the automatic power-down control block.
package apc_pkg;

    localparam int REG_WIDTH = 8;
    localparam int ADDR_WIDTH = 16;
    localparam int DATA_WIDTH = 8;
    localparam int IDLE_CNT_WIDTH = 4;

    // Idle periods of the logic clock before power-down is entered.
    localparam logic [IDLE_CNT_WIDTH-1:0] IDLE_LIMIT = 4'hf;

    // Field positions in power_ctrl_reg_a.
    localparam int REGA_AUTO_SLEEP_EN = 1;
    localparam int REGA_TURBO_OFF = 3;
    localparam int REGA_ARRAY_CLK_OFF = 4;
    localparam int REGA_MCELL_CLK_OFF = 5;

    // Field positions in power_ctrl_reg_b.
    localparam int REGB_WR_OFF = 2;
    localparam int REGB_RD_OFF = 3;
    localparam int REGB_FETCH_OFF = 4;
    localparam int REGB_STROBE_OFF = 5;

    // Values after power-up.
    localparam logic [REG_WIDTH-1:0] REGA_RESET = 8'h00;
    localparam logic [REG_WIDTH-1:0] REGB_RESET = 8'h00;
    localparam logic [ADDR_WIDTH-1:0] ADDR_RESET = 16'h0000;
    localparam logic [DATA_WIDTH-1:0] DATA_RESET = 8'h00;

    // Levels shown to the logic array by a blocked core strobe.
    localparam logic STROBE_N_IDLE = 1'b1;
    localparam logic STROBE_IDLE = 1'b0;

endpackage

// ### src/apc_sleep_counter.sv
// Inactivity counter that raises the power-down flag.
module apc_sleep_counter #(
    parameter int CNT_WIDTH = apc_pkg::IDLE_CNT_WIDTH
) (
    input  wire logic                 ref_clk,
    input  wire logic                 reset,
    input  wire logic                 enable,
    input  wire logic                 strobeActivity,
    input  wire logic                 clockTick,
    input  wire logic                 exitRequest,
    input  wire logic [CNT_WIDTH-1:0] idleLimit,
    output logic                      powerDownFlag,
    output logic [CNT_WIDTH-1:0]      idleCount
);

    logic [CNT_WIDTH-1:0] count_r;
    logic [CNT_WIDTH-1:0] count_nxt;
    logic                 flag_r;
    logic                 flag_nxt;
    logic                 atLimit;
    logic                 holdClear;

    assign atLimit   = (count_r == idleLimit);
    assign holdClear = ~enable | exitRequest | strobeActivity;

    always_comb begin
        count_nxt = count_r;
        flag_nxt  = flag_r;
        if (holdClear) begin
            count_nxt = '0; // R18
            flag_nxt  = 1'b0; // R5
        end else if (clockTick && !atLimit) begin
            count_nxt = count_r + 1'b1; // R1
            flag_nxt  = (count_nxt == idleLimit); // R3
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            count_r <= '0;
            flag_r  <= 1'b0;
        end else begin
            count_r <= count_nxt;
            flag_r  <= flag_nxt;
        end
    end

    assign powerDownFlag = flag_r;
    assign idleCount     = count_r;

endmodule // apc_sleep_counter

// ### src/apc_sync.sv
// Two-stage synchroniser with a change and rising-edge detector.
module apc_sync (
    input  wire logic ref_clk,
    input  wire logic reset,
    input  wire logic asyncIn,
    output logic      syncOut,
    output logic      changed,
    output logic      rose,
    output logic      fell
);

    logic meta_r;
    logic sync_r;
    logic last_r;

    // The first stage feeds only the second stage to keep metastability out.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
        end else begin
            meta_r <= asyncIn;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    assign syncOut = sync_r;
    assign changed = sync_r ^ last_r;
    assign rose    = sync_r & ~last_r;
    assign fell    = ~sync_r & last_r;

endmodule // apc_sync

// ### tb/apc_auto_power_down_control_assertions.sv
// Port-level checks for the automatic power-down control block.
module apc_checker (
    input wire logic        ref_clk,
    input wire logic        reset,
    input wire logic        regAWrite,
    input wire logic [7:0]  regWrData,
    input wire logic [15:0] coreAddr,
    input wire logic [7:0]  powerCtrlRegA,
    input wire logic [7:0]  powerCtrlRegB,
    input wire logic        powerDownFlag,
    input wire logic [15:0] blockAddr,
    input wire logic        flashSelect,
    input wire logic        arrayWrN,
    input wire logic        arrayClock,
    input wire logic        turboModeOn,
    input wire logic        portLevelHold,
    input wire logic [3:0]  idleCount
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    sequence flag_up;
        $rose(powerDownFlag);
    endsequence
    sequence idle_full;
        idleCount == 4'hf;
    endsequence
    reg_load_a: assert property (
        regAWrite |=> powerCtrlRegA == $past(regWrData))
        else $error("register A load wrong");
    turbo_follow_a: assert property (
        turboModeOn == !$past(powerCtrlRegA[3]))
        else $error("turbo mode not tracking bit 3");
    sleep_entry_a: assert property (flag_up |-> idle_full)
        else $error("power-down before fifteen idle periods");
    exit_clear_a: assert property (
        $fell(powerDownFlag) |-> idleCount == 4'h0)
        else $error("idle count not cleared on exit");
    count_step_a: assert property (
        idleCount != $past(idleCount) |->
        idleCount == $past(idleCount) + 4'h1 || idleCount == 4'h0)
        else $error("idle count jumped");
    bus_block_a: assert property (
        powerDownFlag |=> $stable(blockAddr) && !flashSelect)
        else $error("bus not blocked in power-down");
    bus_pass_a: assert property (
        !powerDownFlag |=> blockAddr == $past(coreAddr))
        else $error("address not passed through");
    status_copy_a: assert property (
        portLevelHold == $past(powerDownFlag))
        else $error("port hold not following power-down");
    write_block_a: assert property (powerCtrlRegB[2] |=> arrayWrN)
        else $error("blocked write strobe reached array");
    clock_block_a: assert property (powerCtrlRegA[4] |=> !arrayClock)
        else $error("blocked clock reached array");
    sleep_off_a: assert property (
        !powerCtrlRegA[1] |=> !powerDownFlag)
        else $error("power-down while disabled");
endmodule // apc_checker

bind apc_auto_power_down_control apc_checker apc_checker_inst (
    .ref_clk, .reset, .regAWrite, .regWrData, .coreAddr, .powerCtrlRegA,
    .powerCtrlRegB, .powerDownFlag, .blockAddr, .flashSelect, .arrayWrN,
    .arrayClock, .turboModeOn, .portLevelHold, .idleCount);

// ### tb/apc_core_model.sv
// Behavioural core that drives the address strobe and logic clock pins.
module apc_core_model (
    input  wire logic ref_clk,
    input  wire logic runStrobe,
    input  wire logic runClk,
    output logic      strobePin,
    output logic      logicClockPin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] div;
    initial begin
        div = 2'h0;
        strobePin = 1'b0;
        logicClockPin = 1'b0;
    end
    // Pins move every fourth cycle, keeping below the quarter-rate limit.
    always @(negedge ref_clk) begin
        div <= div + 2'h1;
        if (runStrobe && div == 2'h0) begin
            strobePin <= !strobePin;
        end
        if (runClk && div == 2'h2) begin
            logicClockPin <= !logicClockPin;
        end
    end
endmodule // apc_core_model

// ### tb/tb_auto_power_down_control.sv
// Self-checking testbench for the automatic power-down control block.
module tb_auto_power_down_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk, reset, strobePin, logicClockPin, moduleSelectPinN;
    logic        warmResetPin, regAWrite, regBWrite, coreWrN, coreRdN;
    logic        coreFetchN, flashRequest, sramRequest, ioSpaceRequest;
    logic        runStrobe, runClk, powerDownFlag, flashSelect, sramSelect;
    logic        ioSpaceSelect, arrayWrN, arrayRdN, arrayFetchN, arrayStrobe;
    logic        arrayClock, macrocellClock, turboModeOn, portLevelHold;
    logic        addrOutUndefined, peripheralTristate;
    logic [7:0]  regWrData, coreData, powerCtrlRegA, powerCtrlRegB;
    logic [7:0]  blockData;
    logic [15:0] coreAddr, blockAddr;
    logic [3:0]  idleCount;
    int          n_errors = 0;
    int          tests_run = 0;

    apc_auto_power_down_control apc_auto_power_down_control_inst (
        .ref_clk, .reset, .strobePin, .logicClockPin, .moduleSelectPinN,
        .warmResetPin, .regAWrite, .regBWrite, .regWrData, .coreAddr,
        .coreData, .coreWrN, .coreRdN, .coreFetchN, .flashRequest,
        .sramRequest, .ioSpaceRequest, .powerCtrlRegA, .powerCtrlRegB,
        .powerDownFlag, .blockAddr, .blockData, .flashSelect, .sramSelect,
        .ioSpaceSelect, .arrayWrN, .arrayRdN, .arrayFetchN, .arrayStrobe,
        .arrayClock, .macrocellClock, .turboModeOn, .portLevelHold,
        .addrOutUndefined, .peripheralTristate, .idleCount);
    apc_core_model apc_core_model_inst (
        .ref_clk, .runStrobe, .runClk, .strobePin, .logicClockPin);

    always #4 ref_clk = ~ref_clk;

    task automatic print_verdict();
        $display("Checks run %0d, errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] got, exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic wr(input logic toB, input logic [7:0] d);
        regWrData = d;
        regAWrite = !toB;
        regBWrite = toB;
        cyc(1);
        regAWrite = 1'b0;
        regBWrite = 1'b0;
        cyc(1);
    endtask
    // The clock stops before the last strobe toggle, so a count left over
    // from an earlier wake is cleared and every counted edge is a new one.
    task automatic go_sleep();
        int edges;
        logic last;
        runClk = 1'b0;
        runStrobe = 1'b1;
        cyc(8);
        runStrobe = 1'b0;
        cyc(12);
        edges = 0;
        last = logicClockPin;
        runClk = 1'b1;
        for (int i = 0; i < 300 && powerDownFlag !== 1'b1; i++) begin
            cyc(1);
            if (logicClockPin && !last) edges++;
            last = logicClockPin;
        end
        check(edges, 15, "clock periods to sleep");
        check(idleCount, 4'hf, "idle count at sleep");
    endtask
    task automatic wait_wake(input string what);
        for (int i = 0; i < 12 && powerDownFlag !== 1'b0; i++) cyc(1);
        check(powerDownFlag, 1'b0, what);
    endtask
    task automatic t_reset();
        check({powerCtrlRegA, powerCtrlRegB}, 16'h0000, "regs");
        check(turboModeOn, 1'b1, "turbo default");
        check(powerDownFlag, 1'b0, "flag after reset");
    endtask
    task automatic t_turbo();
        wr(1'b0, 8'h08);
        check(turboModeOn, 1'b0, "turbo off");
        wr(1'b0, 8'h00);
        check(turboModeOn, 1'b1, "turbo on");
    endtask
    task automatic t_block();
        logic seen;
        {coreWrN, coreRdN, coreFetchN} = 3'b000;
        cyc(2);
        check({arrayWrN, arrayRdN, arrayFetchN}, 3'b000, "unblocked");
        wr(1'b1, 8'h3c);
        cyc(2);
        check({arrayWrN, arrayRdN, arrayFetchN}, 3'b111, "strobes");
        wr(1'b0, 8'h30);
        seen = 1'b0;
        repeat (20) begin
            cyc(1);
            seen |= arrayClock | macrocellClock | arrayStrobe;
        end
        check(seen, 1'b0, "clocks and strobe blocked");
        wr(1'b1, 8'h00);
        {coreWrN, coreRdN, coreFetchN} = 3'b111;
    endtask
    task automatic t_sleep();
        logic [15:0] held;
        logic seen;
        wr(1'b0, 8'h02);
        go_sleep();
        cyc(2);
        check({flashSelect, sramSelect, ioSpaceSelect}, 3'b000,
              "memory deselected");
        check({portLevelHold, addrOutUndefined, peripheralTristate}, 3'b111,
              "port effects");
        held = blockAddr;
        coreAddr = ~coreAddr;
        coreData = ~coreData;
        seen = 1'b0;
        repeat (20) begin
            cyc(1);
            seen |= arrayClock & macrocellClock;
        end
        check(blockAddr, held, "address blocked");
        check(blockData, 8'h5a, "data blocked");
        check(seen, 1'b1, "array clock runs");
        runStrobe = 1'b1;
        wait_wake("strobe wake");
        cyc(2);
        check(blockAddr, coreAddr, "address passes again");
        check(blockData, coreData, "data passes again");
        check({flashSelect, sramSelect, ioSpaceSelect}, 3'b111,
              "memory reselected");
    endtask
    task automatic t_exits();
        moduleSelectPinN = 1'b1;
        cyc(4);
        check({flashSelect, sramSelect, ioSpaceSelect}, 3'b000,
              "select pin high");
        check(blockAddr, coreAddr, "select pin keeps bus");
        go_sleep();
        moduleSelectPinN = 1'b0;
        wait_wake("select wake");
        go_sleep();
        warmResetPin = 1'b1;
        wait_wake("warm reset wake");
        warmResetPin = 1'b0;
        check(powerCtrlRegA, 8'h02, "regs kept");
        wr(1'b0, 8'h32);
        go_sleep();
        wr(1'b0, 8'h00);
        check(powerDownFlag, 1'b0, "disable wakes");
    endtask

    initial begin
        ref_clk = 1'b0;
        reset = 1'b1;
        {moduleSelectPinN, warmResetPin, regAWrite, regBWrite} = 4'h0;
        {coreWrN, coreRdN, coreFetchN} = 3'b111;
        {flashRequest, sramRequest, ioSpaceRequest} = 3'b111;
        {runStrobe, runClk} = 2'b11;
        regWrData = 8'h00;
        coreData = 8'h5a;
        coreAddr = 16'h1234;
        cyc(2);
        reset = 1'b0;
        cyc(1);
        t_reset();
        t_turbo();
        t_block();
        t_sleep();
        t_exits();
        print_verdict();
    end
    // Whole run needs about 700 cycles; far past that means a hang.
    initial begin
        cyc(6000);
        n_errors++;
        print_verdict();
    end
endmodule // tb_auto_power_down_control
